// ### bench/low_power_mode_and_clock_sequencer_tb_top.sv
// Purpose: self-checking bench of the low-power sequencer
// Assumes: notes of mode changes are queued before the change happens
// Notes:   values are sampled at the rising edge, before that edge's updates
`timescale 1ns/1ps
module low_power_mode_and_clock_sequencer_tb_top;
  import lps_pkg::*;
  logic clk, rst, go, deep, stby, slow, run, sreq, dp, sb, hlt, xon;
  logic supply_voltage_detector, rtc, twp, ser, cmp, cec, irq, wkp, rst_n, wdg, lpr, pll, xsel, fien, fclr, xclk;
  logic dce, pce, plle, rce, xoe, rlp, roff, drst, rtcr, sext, ff, fi, ahb, apb;
  logic [15:0] evl;
  logic [2:0] rq, rqen, gnt;
  logic [3:0] adiv, pdiv;
  logic [3:0] xc = 4'h0;
  lps_state_type mode, last_mode;
  logic [8:0] q_note[$];
  int fails, check_count, n, k, s, ga, gp, mina, minp, late;

  lps_core_model CORE (.core_clk_in(clk), .sys_rst_in(rst), .go_in(go), .deep_in(deep),
    .stby_in(stby), .slow_in(slow), .core_run_in(run), .sleep_req_out(sreq),
    .deep_sleep_out(dp), .standby_sel_out(sb), .core_halted_out(hlt));
  lps_sequencer DUT (.core_clk_in(clk), .sys_rst_in(rst), .sleep_req_in(sreq),
    .deep_sleep_in(dp), .standby_sel_in(sb), .core_halted_in(hlt), .core_run_out(run),
    .mode_out(mode), .external_event_lines_in(evl), .supply_voltage_detector_in(supply_voltage_detector),
    .rtc_event_in(rtc), .two_wire_port_one_evt_in(twp), .serial_port_one_evt_in(ser),
    .analog_comparators_evt_in(cmp), .cec_evt_in(cec), .periph_irq_in(irq),
    .wakeup_pin_in(wkp), .external_reset_pin_n_in(rst_n), .independent_watchdog_rst_in(wdg),
    .rc_req_in(rq), .rc_req_en_in(rqen), .rc_grant_out(gnt), .stop_lp_reg_in(lpr),
    .pll_on_in(pll), .ext_clk_sel_in(xsel), .clk_fail_irq_en_in(fien),
    .clk_fail_clr_in(fclr), .ahb_div_in(adiv), .apb_div_in(pdiv), .ext_clk_in(xclk),
    .domain_clk_en_out(dce), .periph_clk_en_out(pce), .pll_en_out(plle),
    .internal_rc_osc_en_out(rce), .external_crystal_osc_en_out(xoe),
    .reg_low_power_out(rlp), .reg_off_out(roff), .domain_reset_out(drst),
    .rtc_independent_watchdog_run_out(rtcr), .sys_clk_ext_out(sext), .clk_fail_flag_out(ff),
    .clk_fail_irq_out(fi), .ahb_en_out(ahb), .apb_en_out(apb));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // external clock near 12.5 MHz while enabled
  always @(posedge clk) begin
    xc <= xc + 4'h1;
    xclk <= xon & xc[2];
  end

  task automatic err(input string m);
    fails++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk(input logic a, input logic e);
    check_count++;
    if (a !== e) err("flag differs");
  endtask
  // ----------------------------------------------------------------
  // mode notes: mode, run, domain clk, periph clk, rc osc, reg off, domain reset
  // ----------------------------------------------------------------
  function automatic logic [8:0] nt(lps_state_type m, logic st);
    logic on;
    on = m inside {LPS_RUN, LPS_HALT_WAIT, LPS_SLEEP, LPS_WAKE_RC};
    return {m, m == LPS_RUN, on, on, on, m == LPS_STANDBY,
            st & (m inside {LPS_STANDBY, LPS_WAKE_RC})};
  endfunction
  // compare at the edge after a change, when mode and its outputs have all settled
  always @(posedge clk) begin
    late = (q_note.size() > 0 && mode === last_mode) ? late + 1 : 0;
    if (late == 400) err("mode late or wrong");
    if (!rst && mode !== last_mode) begin
      check_count++;
      if (q_note.size() == 0) err("unexpected mode change");
      else if ({mode, run, dce, pce, rce, roff, drst} !== q_note.pop_front())
        err("mode outputs differ");
    end
    last_mode = mode;
  end
  task automatic wait_mode(input lps_state_type m);
    n = 0;
    do @(posedge clk); while (mode !== m && ++n < 500);
    chk(n < 500, 1'b1);
  endtask
  task automatic enter(input logic d, input logic st);
    lps_state_type t;
    t = !d ? LPS_SLEEP : (st ? LPS_STANDBY : LPS_STOP);
    q_note.push_back(nt(LPS_HALT_WAIT, 1'b0));
    q_note.push_back(nt(t, 1'b1));
    go <= 1'b1;
    deep <= d;
    stby <= st;
    wait_mode(t);
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    err("watchdog expired");
    close_out();
  end

  initial begin
    {go, deep, stby, slow, xon, supply_voltage_detector, rtc, twp, ser, cmp, cec, irq, wkp, wdg} = '0;
    {lpr, pll, xsel, fien, fclr, evl, rq, rqen, adiv, pdiv} = '0;
    rst_n = 1'b1;
    rst = 1'b1;
    fails = 0;
    check_count = 0;
    void'($urandom(32'h8ab4));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    pll <= 1'b1;
    repeat (2) @(posedge clk);
    chk(run, 1'b1);
    chk(rce, 1'b1);
    chk(sext, 1'b0);
    chk(rtcr, 1'b1);
    chk(plle, 1'b1);
    slow <= 1'($urandom % 2);
    enter(1'b0, 1'b0);
    q_note.push_back(nt(LPS_RUN, 1'b0));
    go <= 1'b0;
    irq <= 1'b1;
    wait_mode(LPS_RUN);
    irq <= 1'b0;
    $display("test sleep done");
    lpr <= 1'b1;
    enter(1'b1, 1'b0);
    chk(rlp, 1'b1);
    chk(plle, 1'b0);
    chk(xoe, 1'b0);
    chk(rtcr, 1'b1);
    k = $urandom % 3;
    rqen <= 3'h7;
    rq[k] <= 1'b1;
    repeat (5) @(posedge clk);
    chk(rlp, 1'b0);
    chk(gnt[k], 1'b0);
    n = 0;
    do @(posedge clk); while (gnt[k] !== 1'b1 && ++n < 300);
    chk(n < 300, 1'b1);
    chk(rce, 1'b1);
    q_note.push_back(nt(LPS_WAKE_RC, 1'b0));
    q_note.push_back(nt(LPS_RUN, 1'b0));
    rq <= 3'h0;
    go <= 1'b0;
    evl[$urandom % 16] <= 1'b1;
    wait_mode(LPS_RUN);
    chk(sext, 1'b0);
    evl <= 16'h0;
    $display("test stop done");
    for (s = 0; s < 4; s++) begin
      enter(1'b1, 1'b1);
      chk(roff, 1'b1);
      chk(plle, 1'b0);
      chk(rtcr, 1'b1);
      evl <= 16'hffff;
      repeat (8) @(posedge clk);
      evl <= 16'h0;
      q_note.push_back(nt(LPS_WAKE_RC, 1'b1));
      q_note.push_back(nt(LPS_RUN, 1'b1));
      go <= 1'b0;
      case (s)
        0: rst_n <= 1'b0;
        1: wdg <= 1'b1;
        2: wkp <= 1'b1;
        default: rtc <= 1'b1;
      endcase
      wait_mode(LPS_RUN);
      {rst_n, wdg, wkp, rtc} <= 4'h8;
    end
    $display("test standby done");
    // divisors set early so both prescalers are settled before they are measured
    adiv <= 4'($urandom % 8);
    pdiv <= 4'($urandom % 3);
    fien <= 1'b1;
    xon <= 1'b1;
    xsel <= 1'b1;
    repeat (30) @(posedge clk);
    chk(sext, 1'b1);
    chk(xoe, 1'b1);
    xon <= 1'b0;
    n = 0;
    do @(posedge clk); while (sext !== 1'b0 && ++n < 80);
    repeat (2) @(posedge clk);
    chk(n < 80, 1'b1);
    chk(ff, 1'b1);
    chk(fi, 1'b1);
    chk(rce, 1'b1);
    xsel <= 1'b0;
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ff, 1'b0);
    $display("test clock monitor done");
    // the first pulse only starts the count: the gap before it is partial
    {ga, gp, mina, minp} = {-32'sd999, -32'sd999, 32'd99, 32'd99};
    repeat (300) begin
      @(posedge clk);
      ga++;
      gp++;
      if (ahb === 1'b1) begin
        if (ga >= 0 && ga < mina) mina = ga;
        ga = 0;
      end
      if (apb === 1'b1) begin
        if (gp >= 0 && gp < minp) minp = gp;
        gp = 0;
      end
    end
    chk(mina == ((adiv < 4'h3) ? 3 : adiv), 1'b1);
    chk(minp == 3 * mina, 1'b1);
    $display("test prescaler done");
    close_out();
  end
endmodule

// ### bench/lps_core_model.sv
// Purpose: processor core model facing the low-power sequencer
// Assumes: one clock; the core halts one cycle after it loses run, six with slow_in
// Notes:   slow_in stretches the halt acknowledge
`timescale 1ns/1ps
module lps_core_model (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  // bench control
  input  wire logic go_in,
  input  wire logic deep_in,
  input  wire logic stby_in,
  input  wire logic slow_in,
  // sequencer side
  input  wire logic core_run_in,
  output logic      sleep_req_out,
  output logic      deep_sleep_out,
  output logic      standby_sel_out,
  output logic      core_halted_out
);
  logic [2:0] halt_cnt;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sleep_req_out   <= 1'b0;
      deep_sleep_out  <= 1'b0;
      standby_sel_out <= 1'b0;
      core_halted_out <= 1'b0;
      halt_cnt        <= 3'h0;
    end else begin
      sleep_req_out   <= go_in;
      deep_sleep_out  <= deep_in;
      standby_sel_out <= stby_in;
      halt_cnt        <= core_run_in ? 3'h0 : halt_cnt + {2'h0, halt_cnt != 3'h7};
      // acknowledge only after the sequencer has taken run away
      core_halted_out <= !core_run_in && (halt_cnt >= (slow_in ? 3'h5 : 3'h0));
    end
  end
endmodule

// ### hdl/lps_clk_if.sv
// Purpose: carrier between the sequencer and its external clock monitor
// Assumes: one clock domain
// Notes:   ext_level is already synchronised
`timescale 1ns/1ps
interface lps_clk_if;
  logic ext_level;
  logic mon_en;
  logic fail;
  modport ctl (output ext_level, output mon_en, input fail);
  modport mon (input ext_level, input mon_en, output fail);
endinterface

// ### hdl/lps_clk_monitor.sv
// Purpose: watches the synchronised external clock for missing edges
// Assumes: external clock between 4 and 32 MHz, sampled at 100 MHz
// Notes:   fail is a one-cycle pulse
`timescale 1ns/1ps
`include "lps_consts.svh"
module lps_clk_monitor (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  // monitor carrier
  lps_clk_if.mon    mon
);
  import lps_pkg::*;

  localparam logic [`LPS_CNT_W-1:0] TO_LAST = `LPS_CNT_W'(`LPS_EXT_TIMEOUT_CYC - 1);

  logic                  prev;
  logic [`LPS_CNT_W-1:0] cnt;
  wire                   edge_seen = mon.ext_level ^ prev;
  wire                   expired   = mon.mon_en & ~edge_seen & (cnt == TO_LAST);

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev     <= 1'b0;
      cnt      <= '0;
      mon.fail <= 1'b0;
    end else begin
      prev     <= mon.ext_level;
      mon.fail <= expired;
      if (!mon.mon_en || edge_seen || expired) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  property p_fail_cause;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      mon.fail |-> $past(mon.mon_en) && $past(cnt) == TO_LAST;
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("clock fail without timeout"); // [R13]
endmodule

// ### hdl/lps_consts.svh
// Purpose: offsets-free timing and layout constants of the low-power sequencer
// Assumes: core clock of 100 MHz
// Notes:   cycle counts are derived from the printed times
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define LPS_CLK_MHZ        100
`define LPS_CLK_PERIOD_NS  10

// ----------------------------------------------------------------
// timing (least times, rounded up)
// ----------------------------------------------------------------
`define LPS_RC_START_NS    2000
`define LPS_RC_START_CYC   ((`LPS_RC_START_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
`define LPS_REG_SETTLE_NS  1000
`define LPS_REG_SETTLE_CYC ((`LPS_REG_SETTLE_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
// slowest external clock is 4 MHz (250 ns); two periods without an edge is a failure
`define LPS_EXT_TIMEOUT_NS 500
`define LPS_EXT_TIMEOUT_CYC ((`LPS_EXT_TIMEOUT_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// bus prescalers
// ----------------------------------------------------------------
`define LPS_BUS_MAX_MHZ    48
`define LPS_BUS_MIN_DIV    ((`LPS_CLK_MHZ + `LPS_BUS_MAX_MHZ - 1) / `LPS_BUS_MAX_MHZ)
`define LPS_CNT_W          8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LPS_SYNC_W         30
// external reset pin is active low, so its synchroniser rests high
`define LPS_SYNC_RST       30'h0200_0000

`endif

// ### hdl/lps_pkg.sv
// Purpose: shared types of the low-power sequencer
// Assumes: nothing
// Notes:   state codes are written out
package lps_pkg;

  typedef enum logic [2:0] {
    LPS_RUN       = 3'h0,
    LPS_HALT_WAIT = 3'h1,
    LPS_SLEEP     = 3'h2,
    LPS_STOP      = 3'h3,
    LPS_STANDBY   = 3'h4,
    LPS_WAKE_RC   = 3'h5
  } lps_state_type;

endpackage

// ### hdl/lps_prescaler.sv
// Purpose: divides a tick stream into a slower one-cycle enable
// Assumes: divisor below the bus limit is raised to the least legal one
// Notes:   en_out is registered
`timescale 1ns/1ps
`include "lps_consts.svh"
module lps_prescaler (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  // control
  input  wire logic       tick_in,
  input  wire logic [3:0] div_in,
  // enable
  output logic            en_out
);
  import lps_pkg::*;

  localparam logic [3:0] MIN_DIV = 4'(`LPS_BUS_MIN_DIV);

  logic [3:0] cnt;
  wire  [3:0] div_eff = (div_in < MIN_DIV) ? MIN_DIV : div_in;
  wire        wrap    = tick_in & (cnt >= div_eff - 4'h1);

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt    <= 4'h0;
      en_out <= 1'b0;
    end else begin
      en_out <= wrap;
      if (wrap) begin
        cnt <= 4'h0;
      end else if (tick_in) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ### hdl/lps_sequencer.sv
// Purpose: low-power mode and system clock sequencer
// Assumes: 100 MHz core clock, core halts before a mode is applied
// Notes:   all pin and peripheral events pass a two-stage synchroniser
//
// Summary of operation
// [R1] standby powers the regulator down; core logic contents are lost
// [R2] sleep halts only the core; any peripheral event or interrupt wakes it
// [R3] stop keeps contents, gates core-domain clocks, disables pll and oscillators
// [R4] during stop the regulator follows software: normal or low-power setting
// [R5] any external event line wakes the device from stop
// [R6] cec, serial and two-wire ports may request the rc oscillator in stop
// [R7] with low-power regulator, return it to normal before granting the rc clock
// [R8] standby switches off regulator, pll, rc and crystal oscillators
// [R9] after standby only rtc domain and standby logic survive
// [R10] standby exits on reset pin, watchdog reset, wakeup pin rise or rtc event
// [R11] stop and standby never stop the rtc, watchdog or their clocks
// [R12] reset selects the internal rc oscillator as system clock
// [R13] a selected external clock is monitored continuously for failure
// [R14] on external clock failure fall back to rc and flag an interrupt
// [R15] prescalers derive bus enables, never above 48 MHz
// [R16] core requests a mode and acknowledges halt before it is applied
// [R17] wake from stop restarts the rc oscillator and uses it before release
`timescale 1ns/1ps
`include "lps_consts.svh"
module lps_sequencer (
  // clock and reset
  input  wire logic            core_clk_in,
  input  wire logic            sys_rst_in,
  // processor core handshake
  input  wire logic            sleep_req_in,
  input  wire logic            deep_sleep_in,
  input  wire logic            standby_sel_in,
  input  wire logic            core_halted_in,
  output logic                 core_run_out,
  output lps_pkg::lps_state_type mode_out,
  // wake sources
  input  wire logic [15:0]     external_event_lines_in,
  input  wire logic            supply_voltage_detector_in,
  input  wire logic            rtc_event_in,
  input  wire logic            two_wire_port_one_evt_in,
  input  wire logic            serial_port_one_evt_in,
  input  wire logic            analog_comparators_evt_in,
  input  wire logic            cec_evt_in,
  input  wire logic            periph_irq_in,
  input  wire logic            wakeup_pin_in,
  input  wire logic            external_reset_pin_n_in,
  input  wire logic            independent_watchdog_rst_in,
  // rc clock requests: bit 0 cec, bit 1 serial, bit 2 two-wire
  input  wire logic [2:0]      rc_req_in,
  input  wire logic [2:0]      rc_req_en_in,
  output logic [2:0]           rc_grant_out,
  // configuration
  input  wire logic            stop_lp_reg_in,
  input  wire logic            pll_on_in,
  input  wire logic            ext_clk_sel_in,
  input  wire logic            clk_fail_irq_en_in,
  input  wire logic            clk_fail_clr_in,
  input  wire logic [3:0]      ahb_div_in,
  input  wire logic [3:0]      apb_div_in,
  input  wire logic            ext_clk_in,
  // clock and power controls
  output logic                 domain_clk_en_out,
  output logic                 periph_clk_en_out,
  output logic                 pll_en_out,
  output logic                 internal_rc_osc_en_out,
  output logic                 external_crystal_osc_en_out,
  output logic                 reg_low_power_out,
  output logic                 reg_off_out,
  output logic                 domain_reset_out,
  output logic                 rtc_independent_watchdog_run_out,
  output logic                 sys_clk_ext_out,
  output logic                 clk_fail_flag_out,
  output logic                 clk_fail_irq_out,
  output logic                 ahb_en_out,
  output logic                 apb_en_out
);
  import lps_pkg::*;

  localparam logic [`LPS_CNT_W-1:0] RC_LAST  = `LPS_CNT_W'(`LPS_RC_START_CYC - 1);
  localparam logic [`LPS_CNT_W-1:0] REG_LAST = `LPS_CNT_W'(`LPS_REG_SETTLE_CYC - 1);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [`LPS_SYNC_W-1:0] sync1;
  logic [`LPS_SYNC_W-1:0] sync2;
  logic                   wakeup_pin_prev;
  wire  [`LPS_SYNC_W-1:0] async_vec = {
    ext_clk_in, rc_req_in, external_reset_pin_n_in, independent_watchdog_rst_in,
    wakeup_pin_in, periph_irq_in, cec_evt_in, analog_comparators_evt_in,
    serial_port_one_evt_in, two_wire_port_one_evt_in, rtc_event_in,
    supply_voltage_detector_in, external_event_lines_in};

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1     <= `LPS_SYNC_RST;
      sync2     <= `LPS_SYNC_RST;
      wakeup_pin_prev <= 1'b0;
    end else begin
      sync1     <= async_vec;
      sync2     <= sync1;
      wakeup_pin_prev <= sync2[23];
    end
  end

  // ----------------------------------------------------------------
  // wake decode
  // ----------------------------------------------------------------
  wire       ext_level  = sync2[29];
  wire [2:0] rc_req     = sync2[28:26];
  wire       external_reset_pin_n     = sync2[25];
  wire       wdg_rst    = sync2[24];
  wire       wakeup_pin_rise  = sync2[23] & ~wakeup_pin_prev;
  wire       irq_any    = sync2[22];
  wire       rtc_evt    = sync2[17];
  wire       stop_wake  = |sync2[21:0];                              // [R5]
  wire       sleep_wake = stop_wake | irq_any;                       // [R2]
  wire       stby_wake  = ~external_reset_pin_n | wdg_rst | wakeup_pin_rise | rtc_evt;   // [R10]
  wire [2:0] rc_asked   = rc_req & rc_req_en_in;                     // [R6]
  wire       rc_want    = |rc_asked;

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  lps_state_type         state;
  lps_state_type         next_state;
  logic [`LPS_CNT_W-1:0] wait_cnt;
  logic [`LPS_CNT_W-1:0] reg_cnt;
  logic                  from_stby;
  wire                   wait_done = (wait_cnt == '0);

  always_comb begin
    next_state = state;
    case (state)
      LPS_RUN: begin
        if (sleep_req_in) begin
          next_state = LPS_HALT_WAIT;
        end
      end
      LPS_HALT_WAIT: begin
        // the mode is applied only once the core says it has halted
        if (!sleep_req_in) begin
          next_state = LPS_RUN;
        end else if (core_halted_in) begin // [R16]
          next_state = !deep_sleep_in ? LPS_SLEEP : standby_sel_in ? LPS_STANDBY : LPS_STOP;
        end
      end
      LPS_SLEEP: begin
        if (sleep_wake) begin
          next_state = LPS_RUN; // [R2]
        end
      end
      LPS_STOP: begin
        if (stop_wake) begin
          next_state = LPS_WAKE_RC; // [R5]
        end
      end
      LPS_STANDBY: begin
        if (stby_wake) begin
          next_state = LPS_WAKE_RC; // [R10]
        end
      end
      LPS_WAKE_RC: begin
        if (wait_done) begin
          next_state = LPS_RUN; // [R17]
        end
      end
      default: begin
        next_state = LPS_RUN;
      end
    endcase
  end

  wire entering_stop = (state == LPS_HALT_WAIT) && (next_state == LPS_STOP);
  wire entering_wake = (state != LPS_WAKE_RC) && (next_state == LPS_WAKE_RC);
  wire reg_ready     = ~reg_low_power_out & (reg_cnt == '0);
  wire awake_next    = (next_state == LPS_RUN) || (next_state == LPS_HALT_WAIT) ||
                       (next_state == LPS_SLEEP);
  wire domain_next   = awake_next || (next_state == LPS_WAKE_RC);
  wire stop_next     = (next_state == LPS_STOP);
  wire stby_next     = (next_state == LPS_STANDBY);
  wire keep_reset    = stby_next ||
                       ((next_state == LPS_WAKE_RC) && (state == LPS_STANDBY || from_stby));

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state     <= LPS_RUN;
      wait_cnt  <= '0;
      from_stby <= 1'b0;
    end else begin
      state     <= next_state;
      from_stby <= (state == LPS_STANDBY) | (from_stby & (state == LPS_WAKE_RC));
      if (entering_wake) begin
        wait_cnt <= RC_LAST; // [R17]
      end else if (!wait_done) begin
        wait_cnt <= wait_cnt - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // regulator setting and rc grants in stop
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_low_power_out <= 1'b0;
      reg_cnt           <= '0;
      rc_grant_out      <= 3'h0;
    end else begin
      if (entering_stop) begin
        reg_low_power_out <= stop_lp_reg_in; // [R4]
        reg_cnt           <= '0;
      end else if (state != LPS_STOP) begin
        reg_low_power_out <= 1'b0;
      end else if (rc_want && reg_low_power_out) begin
        // back to normal first; the clock waits for the regulator to settle
        reg_low_power_out <= 1'b0; // [R7]
        reg_cnt           <= REG_LAST;
      end else if (reg_cnt != '0) begin
        reg_cnt <= reg_cnt - 1'b1;
      end
      rc_grant_out <= (state == LPS_STOP && stop_next && reg_ready) ? rc_asked : 3'h0; // [R6]
    end
  end

  // ----------------------------------------------------------------
  // clock selection and failure flag
  // ----------------------------------------------------------------
  lps_clk_if clk_bus ();
  assign clk_bus.ext_level = ext_level;
  assign clk_bus.mon_en    = sys_clk_ext_out; // [R13]

  lps_clk_monitor u_monitor (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .mon         (clk_bus.mon)
  );

  // a failure arriving with the clear keeps the flag set
  wire next_fail = clk_bus.fail | (clk_fail_flag_out & ~clk_fail_clr_in); // [R14]

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sys_clk_ext_out   <= 1'b0; // [R12]
      clk_fail_flag_out <= 1'b0;
      clk_fail_irq_out  <= 1'b0;
    end else begin
      sys_clk_ext_out   <= awake_next & ext_clk_sel_in & ~next_fail; // [R14]
      clk_fail_flag_out <= next_fail;
      clk_fail_irq_out  <= next_fail & clk_fail_irq_en_in;
    end
  end

  // ----------------------------------------------------------------
  // power and clock controls
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_run_out                <= 1'b1;
      domain_clk_en_out           <= 1'b1;
      periph_clk_en_out           <= 1'b1;
      pll_en_out                  <= 1'b0;
      internal_rc_osc_en_out      <= 1'b1;
      external_crystal_osc_en_out <= 1'b0;
      reg_off_out                 <= 1'b0;
      domain_reset_out            <= 1'b0;
      rtc_independent_watchdog_run_out            <= 1'b1;
    end else begin
      core_run_out                <= (next_state == LPS_RUN);     // [R2]
      domain_clk_en_out           <= domain_next;                 // [R3]
      periph_clk_en_out           <= domain_next;                 // [R2]
      pll_en_out                  <= awake_next & pll_on_in;      // [R3] [R8]
      internal_rc_osc_en_out      <= domain_next | (stop_next & rc_want); // [R3] [R6]
      external_crystal_osc_en_out <= awake_next & ext_clk_sel_in; // [R3] [R8]
      reg_off_out                 <= stby_next;                   // [R1] [R8]
      domain_reset_out            <= keep_reset;                  // [R9]
      rtc_independent_watchdog_run_out            <= 1'b1;                        // [R11]
    end
  end

  assign mode_out = state;

  // ----------------------------------------------------------------
  // bus prescalers
  // ----------------------------------------------------------------
  lps_prescaler u_ahb_div (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .tick_in     (domain_clk_en_out),
    .div_in      (ahb_div_in),
    .en_out      (ahb_en_out)
  ); // [R15]

  lps_prescaler u_apb_div (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .tick_in     (ahb_en_out),
    .div_in      (apb_div_in),
    .en_out      (apb_en_out)
  ); // [R15]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_req_lp;
    (state == LPS_STOP) && rc_want && reg_low_power_out;
  endsequence
  sequence s_settling;
    !reg_low_power_out ##0 (rc_grant_out == 3'h0) [*8];
  endsequence
  sequence s_stby_exit;
    (state == LPS_WAKE_RC) && domain_reset_out && internal_rc_osc_en_out;
  endsequence

  property p_stby_off;
    $rose(reg_off_out) |-> !domain_clk_en_out && !internal_rc_osc_en_out && !pll_en_out;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby left power on"); // [R1] [R8]

  property p_sleep_core;
    (state == LPS_SLEEP) && $past(state == LPS_SLEEP) |-> !core_run_out && periph_clk_en_out;
  endproperty
  a_sleep_core: assert property (p_sleep_core) else $error("sleep state wrong"); // [R2]

  property p_stop_clocks;
    (state == LPS_STOP) && $past(state == LPS_STOP) |->
      !domain_clk_en_out && !pll_en_out && !external_crystal_osc_en_out;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clock running in stop"); // [R3]

  property p_stop_reg;
    $rose(state == LPS_STOP) |-> reg_low_power_out == $past(stop_lp_reg_in);
  endproperty
  a_stop_reg: assert property (p_stop_reg) else $error("regulator setting not taken"); // [R4]

  property p_stop_wake;
    (state == LPS_STOP) && stop_wake |=> (state == LPS_WAKE_RC);
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake missed"); // [R5]

  property p_reg_first;
    s_req_lp |=> s_settling;
  endproperty
  a_reg_first: assert property (p_reg_first) else $error("rc granted before settle"); // [R7]

  property p_stby_exit;
    (state == LPS_STANDBY) && stby_wake |=> s_stby_exit;
  endproperty
  a_stby_exit: assert property (p_stby_exit) else $error("standby exit wrong"); // [R9] [R10]

  property p_keep_rtc;
    (state == LPS_STOP) || (state == LPS_STANDBY) |-> rtc_independent_watchdog_run_out;
  endproperty
  a_keep_rtc: assert property (p_keep_rtc) else $error("rtc stopped"); // [R11]

  property p_fail_back;
    clk_bus.fail |=> !sys_clk_ext_out && clk_fail_flag_out;
  endproperty
  a_fail_back: assert property (p_fail_back) else $error("no fallback to rc"); // [R12] [R14]

  property p_bus_rate;
    ahb_en_out |=> !ahb_en_out [*2];
  endproperty
  a_bus_rate: assert property (p_bus_rate) else $error("bus enable too fast"); // [R15]

  property p_wake_rc;
    $rose(state == LPS_WAKE_RC) |-> (internal_rc_osc_en_out && !core_run_out) [*8];
  endproperty
  a_wake_rc: assert property (p_wake_rc) else $error("core released before rc"); // [R17]
endmodule
